/* shared/spm_defines.svh */
// Register offsets, field positions, reset values and timing figures
// What this block does
// - Off request powers down core, keeps wake logic
// - Off mode wakes on detect, reset, debug
// - Every wake from off is system reset
// - Retained RAM blocks and power settings survive off
// - Debug mode only emulates off, resources stay but base resources drop
// - Power-on reset enters on mode, low power
// - Low power: idle blocks off, automatic return
// - Low power: regulators and clocks follow demand
// - Fixed-latency task keeps base resources enabled in on state only
// - Low-power task returns to automatic mode
// - RAM blocks powered off individually, retention kept
// - Supervisor resets at power-up and brownout
// - Brownout level follows current power mode
// - Off to CPU execute takes 36 us
// - WFE resume 22 us, WFI resume 33 us
// - Enable rising edge acts as power-on reset
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SPM_OFF_REQ_OFS 8'h00
`define SPM_FIXLAT_OFS 8'h04
`define SPM_LOW_POWER_TASK_OFS 8'h08
`define SPM_STATUS_OFS 8'h0C
`define SPM_RAMPWR_OFS 8'h10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SPM_TRIG_BIT 0
`define SPM_RAM_ON_BIT 0
`define SPM_RAM_RET_BIT 1
`define SPM_ST_FIXED_LATENCY_TASK_BIT 0
`define SPM_ST_EMUOFF_BIT 1
`define SPM_ST_DEBUG_BIT 2
`define SPM_ST_CPURUN_BIT 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SPM_RAMPWR_RST 2'h1
`define SPM_FIXED_LATENCY_TASK_RST 1'h0

// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define SPM_CLK_MHZ 250
`define SPM_T_OFF2ON_US 36
`define SPM_T_WFE2CPU_US 22
`define SPM_T_WFI2CPU_US 33

`endif

/* shared/spm_pkg.sv */
// Types shared by the power mode sequencer
package spm_pkg;

  // ------------------------------------------------------------
  // Power mode states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ON,
    ST_OFF,
    ST_EMU_OFF,
    ST_WAKE
  } spm_state_t;

endpackage

/* design/spm_delay_counter.sv */
// Loadable down-counter that times wake and resume latencies
`timescale 1ns/100ps
module spm_delay_counter #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [CNT_W-1:0] loadCount,
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_reg; // Cycles still to run
  wire lastCycle = busy && (cnt_reg <= CNT_W'(1));

  // ------------------------------------------------------------
  // Count down; a zero load still takes one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= lastCycle;
      if (start && !busy) begin
        cnt_reg <= loadCount;
        busy <= 1'b1;
      end else if (lastCycle) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end

endmodule // spm_delay_counter

/* design/spm_power_ctrl.sv */
// Power mode sequencer: off mode, wake, sub-modes, RAM power, APB
`timescale 1ns/100ps
`include "spm_defines.svh"
module spm_power_ctrl #(
  parameter int NUM_RAM = 8,
  parameter int NUM_BLK = 4,
  parameter int unsigned OFF2ON_CYC =
    `SPM_T_OFF2ON_US * `SPM_CLK_MHZ,
  parameter int unsigned WFE2CPU_CYC =
    `SPM_T_WFE2CPU_US * `SPM_CLK_MHZ,
  parameter int unsigned WFI2CPU_CYC =
    `SPM_T_WFI2CPU_US * `SPM_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous wake and supply inputs
  input wire logic enablePin,
  input wire logic supplyLow,
  input wire logic pinDetect,
  input wire logic pinReset_b,
  input wire logic debugStart,
  input wire logic debugMode,
  // Same-domain activity and CPU sleep status
  input wire logic [NUM_BLK-1:0] blockActive,
  input wire logic cpuSleepWfe,
  input wire logic cpuSleepWfi,
  input wire logic cpuWakeEvt,
  // Power and clock controls
  output logic sysReset_b,
  output logic coreRunEn,
  output logic cpuClkEn,
  output logic regulatorsOn,
  output logic clocksOn,
  output logic baseResOn,
  output logic [NUM_BLK-1:0] blockClkEn,
  output logic brownoutLevelOn,
  output logic [NUM_RAM-1:0] ramPowerOn,
  output logic [NUM_RAM-1:0] ramRetain,
  output logic offEmulated
);

  localparam int CNT_W = 16;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Order: enable, supplyLow, detect, pin reset, dbg start, dbg mode
  localparam logic [5:0] SYNC_RST = 6'h04;
  logic [5:0] syncA_reg; // First stage, read only by syncB_reg
  logic [5:0] syncB_reg; // Second stage, safe to use
  logic enPrev_reg; // Enable level seen one cycle ago

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      syncA_reg <= SYNC_RST;
      syncB_reg <= SYNC_RST;
      enPrev_reg <= 1'b0;
    end else begin
      syncA_reg <= {enablePin, supplyLow, pinDetect, pinReset_b,
                    debugStart, debugMode};
      syncB_reg <= syncA_reg;
      enPrev_reg <= syncB_reg[5];
    end
  end

  wire enS = syncB_reg[5];
  wire supplyLowS = syncB_reg[4];
  wire detectS = syncB_reg[3];
  wire pinResetS = !syncB_reg[2];
  wire dbgStartS = syncB_reg[1];
  wire dbgModeS = syncB_reg[0];

  // ------------------------------------------------------------
  // Supervisor reset
  // ------------------------------------------------------------
  // Held while disabled or browned out; a fresh enable restarts all
  wire enRise = enS && !enPrev_reg;
  wire porRst = !rst_b || supplyLowS || !enS || enRise;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wrAcc = access && pwrite;
  wire hitOff = (paddr == `SPM_OFF_REQ_OFS);
  wire hitFix = (paddr == `SPM_FIXLAT_OFS);
  wire hitLow = (paddr == `SPM_LOW_POWER_TASK_OFS);
  wire hitSts = (paddr == `SPM_STATUS_OFS);
  wire [7:0] ramOfs = paddr - `SPM_RAMPWR_OFS;
  wire hitRam = (paddr >= `SPM_RAMPWR_OFS) && (paddr[1:0] == 2'h0)
                && (ramOfs[7:2] < 6'(NUM_RAM));
  wire [5:0] ramIdx = ramOfs[7:2];
  wire mapped = hitOff || hitFix || hitLow || hitSts || hitRam;
  wire trigBit = pwdata[`SPM_TRIG_BIT];

  // Task strobes; writing 0 does nothing
  wire offReq = wrAcc && hitOff && trigBit;
  wire fixTask = wrAcc && hitFix && trigBit;
  wire lowTask = wrAcc && hitLow && trigBit;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  spm_pkg::spm_state_t state_reg;
  spm_pkg::spm_state_t state_next;
  logic fixed_latency_task_reg; // Constant-latency sub-mode active
  logic fixed_latency_task_next;
  logic [1:0] ramPwr_reg [NUM_RAM]; // Retained {retain, on}
  logic cpuRun_reg; // CPU clocked and executing
  logic cpuRun_next;
  logic wfiSleep_reg; // Last sleep was WFI, not WFE
  logic cntStart;
  logic [CNT_W-1:0] cntLoad;
  logic cntBusy;
  logic cntDone;

  // Any wake source while off, emulated or not
  wire wakeSrc = detectS || pinResetS || dbgStartS;
  wire inOff = (state_reg == spm_pkg::ST_OFF);
  wire inEmu = (state_reg == spm_pkg::ST_EMU_OFF);
  wire inOn = (state_reg == spm_pkg::ST_ON);
  wire inWake = (state_reg == spm_pkg::ST_WAKE);

  // ------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------
  // Software must have drained DMA and stopped the modem first;
  // the sequencer cuts power without waiting for either.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spm_pkg::ST_ON: begin
        if (pinResetS) begin
          state_next = spm_pkg::ST_WAKE;
        end else if (offReq && dbgModeS) begin
          state_next = spm_pkg::ST_EMU_OFF;
        end else if (offReq) begin
          state_next = spm_pkg::ST_OFF;
        end
      end
      spm_pkg::ST_OFF, spm_pkg::ST_EMU_OFF: begin
        if (wakeSrc) begin
          state_next = spm_pkg::ST_WAKE;
        end
      end
      spm_pkg::ST_WAKE: begin
        if (cntDone) begin
          state_next = spm_pkg::ST_ON;
        end
      end
    endcase
  end

  // Sub-mode: a task for the mode already active is a no-op
  always_comb begin
    fixed_latency_task_next = fixed_latency_task_reg;
    if (inWake) begin
      fixed_latency_task_next = `SPM_FIXED_LATENCY_TASK_RST;
    end else if (inOn && fixTask) begin
      fixed_latency_task_next = 1'b1;
    end else if (inOn && lowTask) begin
      fixed_latency_task_next = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Latency timer control
  // ------------------------------------------------------------
  // One timer serves both the off wake and the sleep resume;
  // a pin reset during a resume starts the wake while the timer is still busy.
  wire enterWake = (state_next == spm_pkg::ST_WAKE) && !inWake;
  wire sleeping = inOn && !cpuRun_reg;
  wire resumeGo = sleeping && cpuWakeEvt && !cntBusy;
  assign cntStart = enterWake || resumeGo;

  always_comb begin
    if (enterWake) begin
      cntLoad = CNT_W'(OFF2ON_CYC);
    end else if (wfiSleep_reg) begin
      cntLoad = CNT_W'(WFI2CPU_CYC);
    end else begin
      cntLoad = CNT_W'(WFE2CPU_CYC);
    end
  end

  spm_delay_counter #(
    .CNT_W(CNT_W)
  ) i_spm_delay_counter (
    .clk_sys(clk_sys),
    .rst_b(!porRst),
    .start(cntStart),
    .loadCount(cntLoad),
    .busy(cntBusy),
    .done(cntDone)
  );

  // CPU run gating
  wire goSleep = inOn && cpuRun_reg && (cpuSleepWfe || cpuSleepWfi);
  always_comb begin
    cpuRun_next = cpuRun_reg;
    if (inOff || inWake) begin
      cpuRun_next = 1'b0;
    end else if (inEmu) begin
      cpuRun_next = 1'b1;
    end else if (goSleep) begin
      cpuRun_next = 1'b0;
    end else if (sleeping && cntDone) begin
      cpuRun_next = 1'b1;
    end
  end

  // Also ends the off wake: CPU starts with the on state
  wire wakeDone = inWake && cntDone;

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  // Power-on reset lands in the on state, low power sub-mode
  always_ff @(posedge clk_sys) begin
    if (porRst) begin
      state_reg <= spm_pkg::ST_ON;
      fixed_latency_task_reg <= `SPM_FIXED_LATENCY_TASK_RST;
      cpuRun_reg <= 1'b1;
      wfiSleep_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fixed_latency_task_reg <= fixed_latency_task_next;
      cpuRun_reg <= cpuRun_next || wakeDone;
      if (goSleep) begin
        wfiSleep_reg <= cpuSleepWfi;
      end
    end
  end

  // ------------------------------------------------------------
  // Retained RAM power settings
  // ------------------------------------------------------------
  // Only the supervisor clears these; an off wake leaves them alone
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_RAM; i++) begin
      if (porRst) begin
        ramPwr_reg[i] <= `SPM_RAMPWR_RST;
      end else if (wrAcc && hitRam && (ramIdx == 6'(i))) begin
        ramPwr_reg[i] <= pwdata[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Read data mux
  // ------------------------------------------------------------
  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0000_0000;
    if (hitSts) begin
      rdData[`SPM_ST_FIXED_LATENCY_TASK_BIT] = fixed_latency_task_reg;
      rdData[`SPM_ST_EMUOFF_BIT] = inEmu;
      rdData[`SPM_ST_DEBUG_BIT] = dbgModeS;
      rdData[`SPM_ST_CPURUN_BIT] = cpuRun_reg;
    end else if (hitRam) begin
      rdData[1:0] = ramPwr_reg[ramIdx[$clog2(NUM_RAM)-1:0]];
    end
  end

  // ------------------------------------------------------------
  // APB answer: no wait states, data registered at setup
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (porRst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdData;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Power control outputs
  // ------------------------------------------------------------
  wire anyActive = |blockActive;
  wire poweredOn = inOn || inEmu;
  // Emulated off keeps clocks, regulators and memories for debug
  wire needPwr = inEmu || fixed_latency_task_reg || anyActive || cpuRun_reg;
  logic [NUM_BLK-1:0] blkEnNext;
  logic [NUM_RAM-1:0] ramOnNext;
  logic [NUM_RAM-1:0] ramRetNext;

  // Idle blocks lose their clock in low power; all run in fixed latency and emulated off, none in off or wake
  always_comb begin
    for (int b = 0; b < NUM_BLK; b++) begin
      blkEnNext[b] = poweredOn &&
        (fixed_latency_task_reg || inEmu || blockActive[b]);
    end
  end

  // Off or idle RAM blocks keep contents only if retained
  always_comb begin
    for (int r = 0; r < NUM_RAM; r++) begin
      ramOnNext[r] = (poweredOn && ramPwr_reg[r][`SPM_RAM_ON_BIT])
                     || inEmu;
      ramRetNext[r] = ramPwr_reg[r][`SPM_RAM_RET_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (porRst) begin
      sysReset_b <= 1'b0;
      coreRunEn <= 1'b0;
      cpuClkEn <= 1'b0;
      regulatorsOn <= 1'b0;
      clocksOn <= 1'b0;
      baseResOn <= 1'b0;
      blockClkEn <= '0;
      brownoutLevelOn <= 1'b1;
      ramPowerOn <= '0;
      ramRetain <= '0;
      offEmulated <= 1'b0;
    end else begin
      sysReset_b <= !inWake;
      coreRunEn <= poweredOn;
      cpuClkEn <= cpuRun_reg;
      regulatorsOn <= poweredOn && needPwr;
      clocksOn <= poweredOn && needPwr;
      baseResOn <= inOn && fixed_latency_task_reg;
      blockClkEn <= blkEnNext;
      brownoutLevelOn <= !inOff;
      ramPowerOn <= ramOnNext;
      ramRetain <= ramRetNext;
      offEmulated <= inEmu;
    end
  end

endmodule // spm_power_ctrl

/* dv/spm_power_checker_properties.sv */
// Port checks for the power mode sequencer
`timescale 1ns/100ps
module spm_power_checker #(
  parameter int unsigned OFF2ON_CYC = 9000
) (
  input logic clk_sys,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic enablePin,
  input logic supplyLow,
  input logic pinDetect,
  input logic pinReset_b,
  input logic debugMode,
  input logic sysReset_b,
  input logic coreRunEn,
  input logic cpuClkEn,
  input logic baseResOn,
  input logic brownoutLevelOn,
  input logic offEmulated
);
  // Upper bound of the wake tail, kept short by the bench parameter
  localparam int WAKE_HI = OFF2ON_CYC - 1;
  // --------
  // Sequences
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Completed write of a trigger bit
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a && pwdata[0];
  endsequence
  // Fully running, not in emulated off
  sequence s_on;
    sysReset_b && coreRunEn && cpuClkEn && !offEmulated;
  endsequence
  // --------
  // Assertions
  // --------
  a_apb_answer: assert property (psel && !penable && sysReset_b |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_supply_reset: assert property (supplyLow[*3] |=>
    !sysReset_b && !cpuClkEn && brownoutLevelOn)
    else $error("no reset on low supply");
  a_off_entry: assert property (!debugMode[*3] ##0 s_on ##0
    s_wr(8'h00) |-> ##2 !coreRunEn && !brownoutLevelOn)
    else $error("off request not taken");
  a_emul_off: assert property (debugMode[*3] ##0 s_on ##0
    s_wr(8'h00) |-> ##2 offEmulated && coreRunEn && cpuClkEn)
    else $error("debug off not emulated");
  a_wake_start: assert property (!coreRunEn && sysReset_b
    ##0 $rose(pinDetect) |-> ##[1:6] !sysReset_b)
    else $error("detect did not wake");
  a_wake_span: assert property ($fell(sysReset_b) && pinReset_b
    && enablePin && !supplyLow |-> !sysReset_b[*8]
    ##[1:WAKE_HI] sysReset_b)
    else $error("wake reset length wrong");
  a_fixlat_on: assert property (s_on ##0 s_wr(8'h04)
    |-> ##[1:3] baseResOn)
    else $error("fixed latency not entered");
  a_low_power_task_back: assert property (s_on ##0 s_wr(8'h08)
    |-> ##[1:3] !baseResOn)
    else $error("low power not resumed");
endmodule // spm_power_checker

bind spm_power_ctrl spm_power_checker #(.OFF2ON_CYC(OFF2ON_CYC))
  i_spm_power_checker (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enablePin(enablePin), .supplyLow(supplyLow), .pinDetect(pinDetect),
  .pinReset_b(pinReset_b), .debugMode(debugMode),
  .sysReset_b(sysReset_b), .coreRunEn(coreRunEn), .cpuClkEn(cpuClkEn),
  .baseResOn(baseResOn), .brownoutLevelOn(brownoutLevelOn),
  .offEmulated(offEmulated));

/* dv/spm_wake_src.sv */
// Wake source model: GPIO detect, reset pin and debug start
`timescale 1ns/100ps
module spm_wake_src (
  input logic clk_sys,
  input logic kick,
  input logic [1:0] src,
  output logic pinDetect,
  output logic pinReset_b,
  output logic debugStart
);
  logic [2:0] holdCnt = 3'h0; // Cycles left on the chosen source
  logic [1:0] srcReg = 2'h0; // 0 detect, 1 reset pin, 2 debug
  // Hold long enough to pass the two-flop synchronisers
  always @(posedge clk_sys) begin
    if (kick) begin
      holdCnt <= 3'h4;
      srcReg <= src;
    end else if (holdCnt != 3'h0) begin
      holdCnt <= holdCnt - 3'h1;
    end
  end
  assign pinDetect = holdCnt != 3'h0 && srcReg == 2'h0;
  // Pin has a pull-up, so it idles high
  assign pinReset_b = !(holdCnt != 3'h0 && srcReg == 2'h1);
  assign debugStart = holdCnt != 3'h0 && srcReg == 2'h2;
endmodule // spm_wake_src

/* dv/spm_power_ctrl_test.sv */
// Self-checking bench for the power mode sequencer
`timescale 1ns/100ps
module spm_power_ctrl_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sysReset_b, coreRunEn, cpuClkEn, baseResOn;
  logic regulatorsOn, clocksOn; // Demand-driven supply and clock enables
  logic enablePin = 1'b1, supplyLow = 1'b0, debugMode = 1'b0;
  logic cpuSleepWfe = 1'b0, cpuSleepWfi = 1'b0, cpuWakeEvt = 1'b0;
  logic pinDetect, pinReset_b, debugStart, brownoutLevelOn, offEmulated;
  logic [1:0] src = 2'h0;
  logic [3:0] blockActive = 4'h0, blockClkEn;
  logic [7:0] ramPowerOn, ramRetain, onExp, retExp;
  logic [32:0] expQ[$]; // Expected {pslverr, prdata} of each read
  logic [32:0] got;
  logic [31:0] lfsr = 32'h088B0DD2; // Fixed seed keeps runs repeatable
  int miscompares = 0, compares = 0, k;

  // Short counts keep the run small
  spm_power_ctrl #(.OFF2ON_CYC(8), .WFE2CPU_CYC(5), .WFI2CPU_CYC(6))
    i_spm_power_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enablePin(enablePin), .supplyLow(supplyLow), .pinDetect(pinDetect),
    .pinReset_b(pinReset_b), .debugStart(debugStart),
    .debugMode(debugMode), .blockActive(blockActive),
    .cpuSleepWfe(cpuSleepWfe), .cpuSleepWfi(cpuSleepWfi),
    .cpuWakeEvt(cpuWakeEvt), .sysReset_b(sysReset_b),
    .coreRunEn(coreRunEn), .cpuClkEn(cpuClkEn),
    .regulatorsOn(regulatorsOn), .clocksOn(clocksOn),
    .baseResOn(baseResOn), .blockClkEn(blockClkEn),
    .brownoutLevelOn(brownoutLevelOn), .ramPowerOn(ramPowerOn),
    .ramRetain(ramRetain), .offEmulated(offEmulated));
  spm_wake_src i_spm_wake_src (.clk_sys(clk_sys), .kick(kick),
    .src(src), .pinDetect(pinDetect), .pinReset_b(pinReset_b),
    .debugStart(debugStart));

  initial forever #2 clk_sys = ~clk_sys;

  // --------
  // Helpers
  // --------
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bounded wait on sysReset_b or cpuClkEn; a miss shows in the check
  task automatic await(input bit rstSel, input logic v, output int n);
    for (n = 0; n < 100 && (rstSel ? sysReset_b : cpuClkEn) !== v; n++)
      @(posedge clk_sys);
  endtask
  // One APB transfer, then an idle edge before the next setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read monitor: oldest expectation against the answer
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      got = expQ.size() > 0 ? expQ.pop_front() : 'x;
      compares++;
      if ({pslverr, prdata} !== got) begin
        miscompares++;
        $display("[ERR] rd %h expected %h seen %h", paddr, got,
          {pslverr, prdata});
      end
    end
  end

  // Watchdog cuts a hang short
  initial begin
    #40000;
    miscompares++;
    final_report;
  end

  // --------
  // Scenarios
  // --------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(5);
    check("levelOn", 8'h1, 8'(brownoutLevelOn));
    rd(8'h0C, 33'h8);
    for (int n = 0; n < 8; n++) begin
      rd(8'h10 + 8'(4 * n), 33'h1);
      lfsr = next_rand(lfsr);
      onExp[n] = lfsr[0];
      retExp[n] = lfsr[1];
      apb(1'b1, 8'h10 + 8'(4 * n), {30'h0, lfsr[1:0]});
    end
    for (int n = 0; n < 8; n++) begin
      rd(8'h10 + 8'(4 * n), {31'h0, retExp[n], onExp[n]});
    end
    check("ramOn", onExp, ramPowerOn);
    check("ramRet", retExp, ramRetain);
    // Unmapped and read-only places are refused or ignored
    rd(8'h40, 33'h1_0000_0000);
    apb(1'b1, 8'h0C, 32'hF);
    rd(8'h0C, 33'h8);
    // Each task twice: the repeat must change nothing
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, n < 2 ? 8'h04 : 8'h08, 32'h1);
      rd(8'h0C, n < 2 ? 33'h9 : 33'h8);
      check("baseRes", 8'(n < 2), 8'(baseResOn));
    end
    lfsr = next_rand(lfsr);
    blockActive <= lfsr[3:0];
    cyc(4);
    check("blkClk", 8'(lfsr[3:0]), 8'(blockClkEn));
    blockActive <= 4'h0;
    // Sleep kinds and their resume latency
    for (int n = 0; n < 2; n++) begin
      cpuSleepWfe <= (n == 0);
      cpuSleepWfi <= (n == 1);
      blockActive <= 4'(n);
      cyc(3);
      check("sleepClk", 8'h0, 8'(cpuClkEn));
      check("supply", 8'(3 * n), 8'({regulatorsOn, clocksOn}));
      cpuSleepWfe <= 1'b0;
      cpuSleepWfi <= 1'b0;
      blockActive <= 4'h0;
      cpuWakeEvt <= 1'b1;
      cyc(1);
      cpuWakeEvt <= 1'b0;
      await(1'b0, 1'b1, k);
      check("resume", 8'h1, 8'(k >= 4 + n && k <= 10 + n));
    end
    // Off by each wake source, then emulated off in debug
    for (int w = 0; w < 4; w++) begin
      debugMode <= (w == 3);
      apb(1'b1, 8'h04, 32'h1);
      // DMA stopped, modem stopped, software now spins in place
      apb(1'b1, 8'h00, 32'h1);
      cyc(2);
      check("coreRun", 8'(w == 3), 8'(coreRunEn));
      check("emuOff", 8'(w == 3), 8'(offEmulated));
      check("level", 8'(w == 3), 8'(brownoutLevelOn));
      if (w < 3) check("retain", retExp, ramRetain);
      check("ramPwr", w == 3 ? 8'hFF : 8'h0, ramPowerOn);
      check("supOff", 8'(3 * (w == 3)), 8'({regulatorsOn, clocksOn}));
      src <= (w == 3) ? 2'h0 : 2'(w);
      kick <= 1'b1;
      cyc(1);
      kick <= 1'b0;
      await(1'b1, 1'b0, k);
      await(1'b1, 1'b1, k);
      check("wake", 8'h1, 8'(k >= 7 && k <= 15));
      debugMode <= 1'b0;
      cyc(4);
      rd(8'h0C, 33'h8);
      rd(8'h14, {31'h0, retExp[1], onExp[1]});
    end
    // Brownout, then an enable cycle acting as power-on
    supplyLow <= 1'b1;
    cyc(5);
    check("borRst", 8'h0, 8'(sysReset_b));
    supplyLow <= 1'b0;
    await(1'b1, 1'b1, k);
    cyc(2);
    rd(8'h14, 33'h1);
    // Leave a non-reset setting so the enable cycle must clear it
    apb(1'b1, 8'h14, 32'h2);
    enablePin <= 1'b0;
    cyc(5);
    enablePin <= 1'b1;
    await(1'b1, 1'b1, k);
    cyc(2);
    rd(8'h14, 33'h1);
    final_report;
  end
endmodule // spm_power_ctrl_test
